/* File: common/gpm_pkg.sv */
package gpm_pkg;

    // Clock rate and every time figure, with the cycle counts derived from them.
    localparam longint CLK_HZ = 100_000_000;
    localparam longint DISP_TO_MIN = 30;
    localparam longint DISP_TO_CYC = DISP_TO_MIN * 60 * CLK_HZ;
    localparam longint LAMP_TO_MIN = 10;
    localparam longint LAMP_TO_CYC = LAMP_TO_MIN * 60 * CLK_HZ;
    localparam longint DEB_MS = 10;
    localparam longint DEB_CYC = (DEB_MS * CLK_HZ + 999) / 1000;
    localparam longint FLASH_MS = 500;
    localparam longint FLASH_CYC = FLASH_MS * CLK_HZ / 1000;
    localparam longint HOLD_MS = 2000;
    localparam longint HOLD_CYC = (HOLD_MS * CLK_HZ + 999) / 1000;
    localparam longint BAR_MS = 250;
    localparam longint BAR_CYC = BAR_MS * CLK_HZ / 1000;

    // Counter widths: long timers and the per-input debounce counters.
    localparam int TW = 38;
    localparam int DW = 24;

    // Positions of the panel and remote inputs in the debounced vector.
    localparam int IN_ESTOP = 0;
    localparam int IN_OFF = 1;
    localparam int IN_MAN = 2;
    localparam int IN_AUTO = 3;
    localparam int IN_ACK = 4;
    localparam int IN_LAMP = 5;
    localparam int IN_RUN = 6;
    localparam int IN_RSTART = 7;
    localparam int IN_RRESET = 8;
    localparam int IN_MENU = 9;
    localparam int NMENU = 4;
    localparam int NIN = 13;

    // Register map, byte addresses on the Avalon slave.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int CTL_SLEEP_EN = 0;
    localparam int CTL_MENU_LSB = 4;

    // Status word bit positions.
    localparam int ST_SLEEP = 0;
    localparam int ST_DISP = 1;
    localparam int ST_ESTOP = 2;
    localparam int ST_SHUT = 3;
    localparam int ST_WARN = 4;
    localparam int ST_RUN = 5;
    localparam int ST_CFGERR = 6;
    localparam int ST_PANEL = 7;
    localparam int ST_LTEST = 8;
    localparam int ST_SEL_LSB = 9;

    typedef enum logic [2:0] {
        PWR_AWAKE = 3'b001,
        PWR_INIT = 3'b010,
        PWR_SLEEP = 3'b100
    } gpm_pwr_t;

endpackage

/* File: hw/gpm_panel.sv */
// Overview of operation
// RULE1: Display power goes off after thirty idle minutes, running or not.
// RULE2: Any press, switch move or received signal restarts the display timer.
// RULE3: Screen saver blanks only the display; LEDs keep working.
// RULE4: A detected warning shows its message on the display.
// RULE5: In sleep, sequencing stops and all LEDs and display are off.
// RULE6: Sleep needs enable, no unacknowledged fault, and selector at off.
// RULE7: Selector, emergency stop, acknowledge or lamp button wakes and reinitialises.
// RULE8: Sleep enable resets disabled; disabled means always awake; clearing it during sleep does not wake the panel.
// RULE9: With network option fitted, sleep is blocked and enabling flags error.
// RULE10: Menu buttons show a symbol only when usable; others are ignored.
// RULE11: Emergency stop halts engine at once and inhibits all starts.
// RULE12: Estop clears by release, selector off, local acknowledge; not remote reset.
// RULE13: Running lamp follows engine; remote start lamp follows remote request.
// RULE14: Not-in-auto lamp flashes whenever selector is not at auto.
// RULE15: Shutdown lamp lights on shutdown and inhibits every start.
// RULE16: Shutdown clears after condition ends, on acknowledge with selector off.
// RULE17: Warning clears after condition, on acknowledge or remote reset cycle in auto.
// RULE18: Latching warnings stay after acknowledge until the engine has stopped.
// RULE19: Acknowledge drops faults; warnings any position, shutdowns only at off.
// RULE20: Short lamp press toggles lamps with timeout; hold tests LEDs and meters.
// RULE21: Manual run/stop acts only in manual, no delays; auto uses remote.
// RULE22: Off prevents starts and stops a running engine at once.
// RULE23: Inputs are synchronised, debounced and handled as single events.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
module gpm_panel #(
    parameter longint DISP_TO_CYC = gpm_pkg::DISP_TO_CYC,
    parameter longint LAMP_TO_CYC = gpm_pkg::LAMP_TO_CYC,
    parameter longint DEB_CYC = gpm_pkg::DEB_CYC,
    parameter longint FLASH_CYC = gpm_pkg::FLASH_CYC,
    parameter longint HOLD_CYC = gpm_pkg::HOLD_CYC,
    parameter longint BAR_CYC = gpm_pkg::BAR_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic estop_pin,
    input wire logic sel_off_pin,
    input wire logic sel_man_pin,
    input wire logic sel_auto_pin,
    input wire logic ack_pin,
    input wire logic lamp_pin,
    input wire logic run_pin,
    input wire logic [3:0] menu_pin,
    input wire logic remote_start_pin,
    input wire logic remote_reset_pin,
    input wire logic net_opt_pin,
    input wire logic warn_cond,
    input wire logic warn_latching,
    input wire logic shut_cond,
    output logic engine_run,
    output logic hot_stop,
    output logic delay_bypass,
    output logic ctrl_active,
    output logic ctrl_init,
    output logic disp_power,
    output logic warn_msg,
    output logic [3:0] menu_symbol,
    output logic [3:0] menu_event,
    output logic run_lamp,
    output logic rstart_lamp,
    output logic nauto_lamp,
    output logic shut_lamp,
    output logic warn_lamp,
    output logic panel_lamp,
    output logic lamp_test,
    output logic [2:0] meter_bar,
    output logic cfg_err
);

    localparam int TW = gpm_pkg::TW;
    localparam int DW = gpm_pkg::DW;
    localparam int NIN = gpm_pkg::NIN;

    logic [NIN-1:0] pins;
    logic [NIN-1:0] db;
    logic [NIN-1:0] db_q_ff;
    logic [NIN-1:0] rise;
    logic [NIN-1:0] fall;
    gpm_pkg::gpm_pwr_t pwr_ff;
    logic awake;
    logic wake_ev;
    logic any_ev;
    logic sleep_ok;
    logic stop_now;
    logic [TW-1:0] disp_cnt_ff;
    logic disp_exp;
    logic opt_s1_ff;
    logic opt_ff;
    logic warn_q_ff;
    logic shut_q_ff;
    logic estop_ff;
    logic shut_ff;
    logic warn_ff;
    logic hold_ff;
    logic run_ff;
    logic [TW-1:0] flash_cnt_ff;
    logic flash_ff;
    logic [TW-1:0] hold_cnt_ff;
    logic lt_ff;
    logic [TW-1:0] lamp_cnt_ff;
    logic panel_ff;
    logic [TW-1:0] bar_cnt_ff;
    logic [2:0] bar_ff;
    logic [7:0] ctrl_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] stat;
    logic hot_ff;
    logic bypass_ff;
    logic active_ff;
    logic init_ff;
    logic disp_ff;
    logic msg_ff;
    logic [3:0] sym_ff;
    logic [3:0] mevt_ff;
    logic run_lamp_ff;
    logic rstart_lamp_ff;
    logic nauto_lamp_ff;
    logic shut_lamp_ff;
    logic warn_lamp_ff;
    logic cfg_err_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning.

    assign pins = {menu_pin, remote_reset_pin, remote_start_pin, run_pin, lamp_pin,
                   ack_pin, sel_auto_pin, sel_man_pin, sel_off_pin, estop_pin};

    // Each input passes two flops, then must hold a new level for the whole
    // debounce time before it is accepted, so contact bounce makes one event.
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_db
            logic s1_ff;
            logic s2_ff;
            logic lvl_ff;
            logic [DW-1:0] cnt_ff;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    lvl_ff <= 1'b0;
                    cnt_ff <= '0;
                end else begin
                    s1_ff <= pins[gi];
                    s2_ff <= s1_ff;
                    if (s2_ff == lvl_ff) begin
                        cnt_ff <= '0;
                    end else if (cnt_ff == DW'(DEB_CYC - 1)) begin
                        cnt_ff <= '0;
                        lvl_ff <= s2_ff; // [RULE23]
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
            end
            assign db[gi] = lvl_ff;
        end
    endgenerate

    // Edge detection turns each accepted level change into a one-cycle event.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            db_q_ff <= '0;
            opt_s1_ff <= 1'b0;
            opt_ff <= 1'b0;
            warn_q_ff <= 1'b0;
            shut_q_ff <= 1'b0;
        end else begin
            db_q_ff <= db;
            opt_s1_ff <= net_opt_pin;
            opt_ff <= opt_s1_ff;
            warn_q_ff <= warn_cond;
            shut_q_ff <= shut_cond;
        end
    end

    assign rise = db & ~db_q_ff; // [RULE23]
    assign fall = ~db & db_q_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Power modes: awake, one-cycle reinitialise, sleep.

    assign awake = (pwr_ff != gpm_pkg::PWR_SLEEP);
    assign wake_ev = rise[gpm_pkg::IN_ESTOP] | fall[gpm_pkg::IN_ESTOP] | rise[gpm_pkg::IN_ACK]
                   | rise[gpm_pkg::IN_LAMP] | (db[gpm_pkg::IN_OFF] ^ db_q_ff[gpm_pkg::IN_OFF])
                   | (db[gpm_pkg::IN_MAN] ^ db_q_ff[gpm_pkg::IN_MAN])
                   | (db[gpm_pkg::IN_AUTO] ^ db_q_ff[gpm_pkg::IN_AUTO]); // [RULE7]
    // Sleep also waits for the idle timer so that a wake press is not undone
    // in the very next cycle while the selector still sits at off.
    assign sleep_ok = ctrl_ff[gpm_pkg::CTL_SLEEP_EN] && !opt_ff && !estop_ff && !shut_ff
                    && !warn_ff && db[gpm_pkg::IN_OFF] && disp_exp; // [RULE6] [RULE8] [RULE9]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_ff <= gpm_pkg::PWR_AWAKE;
        end else begin
            case (pwr_ff)
                gpm_pkg::PWR_AWAKE: begin
                    if (sleep_ok) begin
                        pwr_ff <= gpm_pkg::PWR_SLEEP;
                    end
                end
                gpm_pkg::PWR_SLEEP: begin
                    // A fitted option strap forbids sleep, so it also wakes the panel.
                    if (wake_ev || opt_ff) begin
                        pwr_ff <= gpm_pkg::PWR_INIT; // [RULE7] [RULE9]
                    end
                end
                gpm_pkg::PWR_INIT: pwr_ff <= gpm_pkg::PWR_AWAKE;
                default: pwr_ff <= gpm_pkg::PWR_AWAKE;
            endcase
        end
    end

    // Inactivity timer saturates at expiry; any event restarts it.
    assign any_ev = |(db ^ db_q_ff) | (warn_cond & ~warn_q_ff) | (shut_cond & ~shut_q_ff);
    assign disp_exp = (disp_cnt_ff == TW'(DISP_TO_CYC - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            disp_cnt_ff <= '0;
        end else if (any_ev || pwr_ff == gpm_pkg::PWR_INIT) begin
            disp_cnt_ff <= '0; // [RULE2]
        end else if (!disp_exp) begin
            disp_cnt_ff <= disp_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault latches. Each set term is tested first, so a set wins over a clear.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            estop_ff <= 1'b0;
        end else if (db[gpm_pkg::IN_ESTOP]) begin
            estop_ff <= 1'b1; // [RULE11]
        end else if (rise[gpm_pkg::IN_ACK] && db[gpm_pkg::IN_OFF]) begin
            estop_ff <= 1'b0; // [RULE12]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shut_ff <= 1'b0;
        end else if (shut_cond) begin
            shut_ff <= 1'b1; // [RULE15]
        end else if (rise[gpm_pkg::IN_ACK] && db[gpm_pkg::IN_OFF]) begin
            shut_ff <= 1'b0; // [RULE16] [RULE19]
        end
    end

    // A latching warning pins the indication until the engine is stopped.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_ff <= 1'b0;
        end else if (warn_cond && warn_latching) begin
            hold_ff <= 1'b1;
        end else if (!run_ff) begin
            hold_ff <= 1'b0; // [RULE18]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            warn_ff <= 1'b0;
        end else if (warn_cond) begin
            warn_ff <= 1'b1; // [RULE17]
        end else if (!hold_ff && (rise[gpm_pkg::IN_ACK]
                     || (db[gpm_pkg::IN_AUTO] && fall[gpm_pkg::IN_RRESET]))) begin
            warn_ff <= 1'b0; // [RULE17] [RULE19]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine run command. Stop terms win and act in the cycle they appear,
    // with no cool-down; this costs a hot stop but keeps the stop immediate.

    assign stop_now = db[gpm_pkg::IN_ESTOP] | estop_ff | shut_cond | shut_ff
                    | db[gpm_pkg::IN_OFF] | ~awake; // [RULE5] [RULE11] [RULE15] [RULE22]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_ff <= 1'b0;
        end else if (stop_now) begin
            run_ff <= 1'b0;
        end else if (db[gpm_pkg::IN_MAN]) begin
            if (rise[gpm_pkg::IN_RUN]) begin
                run_ff <= ~run_ff; // [RULE21]
            end
        end else if (db[gpm_pkg::IN_AUTO]) begin
            run_ff <= db[gpm_pkg::IN_RSTART]; // [RULE21]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hot_ff <= 1'b0;
            bypass_ff <= 1'b0;
            active_ff <= 1'b0;
            init_ff <= 1'b0;
        end else begin
            hot_ff <= run_ff & rise[gpm_pkg::IN_OFF]; // [RULE22]
            bypass_ff <= db[gpm_pkg::IN_MAN] | db[gpm_pkg::IN_OFF]; // [RULE21]
            active_ff <= awake; // [RULE5]
            init_ff <= (pwr_ff == gpm_pkg::PWR_INIT); // [RULE7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flasher, panel lamp toggle with timeout, and held-button lamp test.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_cnt_ff <= '0;
            flash_ff <= 1'b0;
        end else if (flash_cnt_ff == TW'(FLASH_CYC - 1)) begin
            flash_cnt_ff <= '0;
            flash_ff <= ~flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_cnt_ff <= '0;
            lt_ff <= 1'b0;
        end else if (!db[gpm_pkg::IN_LAMP] || !awake) begin
            hold_cnt_ff <= '0;
            lt_ff <= 1'b0;
        end else if (hold_cnt_ff == TW'(HOLD_CYC - 1)) begin
            lt_ff <= 1'b1; // [RULE20]
        end else begin
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
        end
    end

    // The toggle acts on release, so a long press tests lamps without toggling.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            panel_ff <= 1'b0;
            lamp_cnt_ff <= '0;
        end else if (!awake) begin
            panel_ff <= 1'b0;
            lamp_cnt_ff <= '0;
        end else if (fall[gpm_pkg::IN_LAMP] && !lt_ff) begin
            panel_ff <= ~panel_ff; // [RULE20]
            lamp_cnt_ff <= '0;
        end else if (panel_ff) begin
            if (lamp_cnt_ff == TW'(LAMP_TO_CYC - 1)) begin
                panel_ff <= 1'b0; // [RULE20]
            end else begin
                lamp_cnt_ff <= lamp_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bar_cnt_ff <= '0;
            bar_ff <= 3'h0;
        end else if (!lt_ff) begin
            bar_cnt_ff <= '0;
            bar_ff <= 3'h0;
        end else if (bar_cnt_ff == TW'(BAR_CYC - 1)) begin
            bar_cnt_ff <= '0;
            bar_ff <= bar_ff + 3'h1; // [RULE20]
        end else begin
            bar_cnt_ff <= bar_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indicator outputs. LEDs depend on awake only, never on the screen saver.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            disp_ff <= 1'b0;
            msg_ff <= 1'b0;
            sym_ff <= 4'h0;
            mevt_ff <= 4'h0;
            run_lamp_ff <= 1'b0;
            rstart_lamp_ff <= 1'b0;
            nauto_lamp_ff <= 1'b0;
            shut_lamp_ff <= 1'b0;
            warn_lamp_ff <= 1'b0;
            cfg_err_ff <= 1'b0;
        end else begin
            disp_ff <= awake && !disp_exp; // [RULE1] [RULE5]
            msg_ff <= awake && warn_ff; // [RULE4]
            sym_ff <= (awake && !disp_exp) ? ctrl_ff[gpm_pkg::CTL_MENU_LSB +: 4] : 4'h0; // [RULE10]
            mevt_ff <= rise[gpm_pkg::IN_MENU +: 4] & sym_ff; // [RULE10]
            run_lamp_ff <= awake && (run_ff || lt_ff); // [RULE3] [RULE13]
            rstart_lamp_ff <= awake && (db[gpm_pkg::IN_RSTART] || lt_ff); // [RULE13]
            nauto_lamp_ff <= awake && ((!db[gpm_pkg::IN_AUTO] && flash_ff) || lt_ff); // [RULE14]
            shut_lamp_ff <= awake && (shut_ff || lt_ff); // [RULE15]
            warn_lamp_ff <= awake && (warn_ff || lt_ff); // [RULE17]
            cfg_err_ff <= ctrl_ff[gpm_pkg::CTL_SLEEP_EN] && opt_ff; // [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, write commits when waitrequest is low.

    assign stat = {20'h0, db[gpm_pkg::IN_AUTO], db[gpm_pkg::IN_MAN], db[gpm_pkg::IN_OFF],
                   lt_ff, panel_ff, cfg_err_ff, run_ff, warn_ff, shut_ff, estop_ff, disp_ff, ~awake};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= 1'b1;
            if ((avs_read || avs_write) && wait_ff) begin
                wait_ff <= 1'b0;
                if (avs_address == gpm_pkg::REG_CTRL) begin
                    rdata_ff <= {24'h0, ctrl_ff};
                end else if (avs_address == gpm_pkg::REG_STAT) begin
                    rdata_ff <= stat;
                end else begin
                    rdata_ff <= 32'h0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= gpm_pkg::CTRL_RST; // [RULE8]
        end else if (avs_write && !wait_ff && avs_address == gpm_pkg::REG_CTRL) begin
            ctrl_ff <= avs_writedata[7:0];
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign engine_run = run_ff;
    assign hot_stop = hot_ff;
    assign delay_bypass = bypass_ff;
    assign ctrl_active = active_ff;
    assign ctrl_init = init_ff;
    assign disp_power = disp_ff;
    assign warn_msg = msg_ff;
    assign menu_symbol = sym_ff;
    assign menu_event = mevt_ff;
    assign run_lamp = run_lamp_ff;
    assign rstart_lamp = rstart_lamp_ff;
    assign nauto_lamp = nauto_lamp_ff;
    assign shut_lamp = shut_lamp_ff;
    assign warn_lamp = warn_lamp_ff;
    assign panel_lamp = panel_ff;
    assign lamp_test = lt_ff;
    assign meter_bar = bar_ff;
    assign cfg_err = cfg_err_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_ESTOP_STOP: assert property (db[gpm_pkg::IN_ESTOP] |=> !run_ff) // [RULE11]
        else $error("engine still runs after emergency stop");
    AST_ESTOP_HOLD: assert property (estop_ff && !(rise[gpm_pkg::IN_ACK] && db[gpm_pkg::IN_OFF])
        |=> estop_ff) // [RULE12]
        else $error("emergency stop latch cleared out of sequence");
    AST_SLEEP_DARK: assert property (pwr_ff == gpm_pkg::PWR_SLEEP ##1 pwr_ff == gpm_pkg::PWR_SLEEP
        |-> !run_lamp_ff && !warn_lamp_ff && !disp_ff && !run_ff) // [RULE5]
        else $error("indicator lit during sleep");
    AST_SLEEP_ENTRY: assert property ($rose(pwr_ff == gpm_pkg::PWR_SLEEP)
        |-> $past(ctrl_ff[gpm_pkg::CTL_SLEEP_EN]) && $past(db[gpm_pkg::IN_OFF]) && !$past(shut_ff)) // [RULE6]
        else $error("sleep entered without its conditions");
    AST_WAKE_SEQ: assert property (pwr_ff == gpm_pkg::PWR_SLEEP && wake_ev
        |=> pwr_ff == gpm_pkg::PWR_INIT ##1 pwr_ff == gpm_pkg::PWR_AWAKE && init_ff) // [RULE7]
        else $error("wake sequence wrong");
    AST_SHUT_INHIBIT: assert property (shut_ff |=> !$rose(run_ff)) // [RULE15]
        else $error("start while shutdown latched");
    AST_OFF_STOP: assert property (db[gpm_pkg::IN_OFF] ##1 db[gpm_pkg::IN_OFF] |-> !run_ff) // [RULE22]
        else $error("engine runs with selector off");
    AST_MENU_IGNORE: assert property (|mevt_ff |-> (mevt_ff & ~$past(sym_ff)) == 4'h0) // [RULE10]
        else $error("menu press taken without symbol");
    AST_CFG_ERR: assert property (ctrl_ff[gpm_pkg::CTL_SLEEP_EN] && opt_ff |=> cfg_err_ff
        ##0 pwr_ff != gpm_pkg::PWR_SLEEP) // [RULE9]
        else $error("sleep with option fitted not flagged");

endmodule

/* File: sim/gpm_operator.sv */
module gpm_operator (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [12:0] want,
    output logic [12:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////
    // Contacts move just after an edge; the bench orders estop release, off and ack.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins <= 13'h0;
        end else begin
            pins <= want;
        end
    end
endmodule

/* File: sim/genset_panel_mode_control_tb.sv */
module genset_panel_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, rd, wr, net_opt, warn_c, shut_c, wreq, eng, act, disp, rlamp, slamp, cerr;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [12:0] want, pins;
    int miscompares = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////
    gpm_operator u_gpm_operator (.clk(clk), .nrst(nrst), .want(want), .pins(pins));
    gpm_panel #(.DISP_TO_CYC(200), .LAMP_TO_CYC(100), .DEB_CYC(4), .FLASH_CYC(8), .HOLD_CYC(50),
        .BAR_CYC(5)) u_gpm_panel (.clk(clk), .nrst(nrst), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .estop_pin(pins[0]), .sel_off_pin(pins[1]), .sel_man_pin(pins[2]), .sel_auto_pin(pins[3]),
        .ack_pin(pins[4]), .lamp_pin(pins[5]), .run_pin(pins[6]), .menu_pin(pins[12:9]),
        .remote_start_pin(pins[7]), .remote_reset_pin(pins[8]), .net_opt_pin(net_opt),
        .warn_cond(warn_c), .warn_latching(1'h0), .shut_cond(shut_c), .engine_run(eng),
        .hot_stop(), .delay_bypass(), .ctrl_active(act), .ctrl_init(), .disp_power(disp),
        .warn_msg(), .menu_symbol(), .menu_event(), .run_lamp(rlamp), .rstart_lamp(),
        .nauto_lamp(), .shut_lamp(slamp), .warn_lamp(), .panel_lamp(), .lamp_test(),
        .meter_bar(), .cfg_err(cerr));
    ////////////////////////////////////////////////////////////////
    // Free running 100 MHz clock.
    always #5 clk = ~clk;
    task automatic summarize();
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    // One Avalon cycle; the request stands until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] r);
        int i;
        @(posedge clk);
        addr <= a;
        wdata <= v;
        if (w) wr <= 1'h1;
        else rd <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wreq === 1'h0) break;
        end
        r = rdata;
        wr <= 1'h0;
        rd <= 1'h0;
        if (i == 20) begin
            miscompares++;
            summarize();
        end
    endtask
    // A pin change needs the partner flop, two sync flops, debounce and reaction time.
    task automatic pin(input int idx, input logic v);
        @(posedge clk);
        want[idx] <= v;
        repeat (12) @(posedge clk);
    endtask
    task automatic press(input int idx);
        pin(idx, 1'h1);
        pin(idx, 1'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence; idle waits are longer than the shortened display timeout.
    initial begin
        clk = 0; nrst = 0; addr = 4'h0; rd = 0; wr = 0; wdata = 32'h0; want = 13'h0;
        net_opt = 0; warn_c = 0; shut_c = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        bus(1'h0, gpm_pkg::REG_CTRL, 32'h0, d);
        chk("ctrl", 32'h0, d);
        bus(1'h0, 4'hC, 32'h0, d);
        chk("unmapped", 32'h0, d);
        $display("Test reset done");
        pin(gpm_pkg::IN_MAN, 1'h1);
        press(gpm_pkg::IN_RUN);
        chk("engine_run", 32'h1, eng);
        chk("run_lamp", 32'h1, rlamp);
        pin(gpm_pkg::IN_ESTOP, 1'h1);
        chk("engine_run", 32'h0, eng);
        press(gpm_pkg::IN_RUN);
        chk("engine_run", 32'h0, eng);
        pin(gpm_pkg::IN_ESTOP, 1'h0);
        pin(gpm_pkg::IN_MAN, 1'h0);
        pin(gpm_pkg::IN_OFF, 1'h1);
        bus(1'h0, gpm_pkg::REG_STAT, 32'h0, d);
        chk("estop", 32'h1, d[gpm_pkg::ST_ESTOP]);
        press(gpm_pkg::IN_ACK);
        bus(1'h0, gpm_pkg::REG_STAT, 32'h0, d);
        chk("estop", 32'h0, d[gpm_pkg::ST_ESTOP]);
        $display("Test estop done");
        pin(gpm_pkg::IN_OFF, 1'h0);
        pin(gpm_pkg::IN_MAN, 1'h1);
        press(gpm_pkg::IN_RUN);
        pin(gpm_pkg::IN_MAN, 1'h0);
        pin(gpm_pkg::IN_OFF, 1'h1);
        chk("engine_run", 32'h0, eng);
        shut_c <= 1'h1;
        pin(gpm_pkg::IN_OFF, 1'h0);
        pin(gpm_pkg::IN_MAN, 1'h1);
        chk("shut_lamp", 32'h1, slamp);
        shut_c <= 1'h0;
        press(gpm_pkg::IN_ACK);
        chk("shut_lamp", 32'h1, slamp);
        press(gpm_pkg::IN_RUN);
        chk("engine_run", 32'h0, eng);
        pin(gpm_pkg::IN_MAN, 1'h0);
        pin(gpm_pkg::IN_OFF, 1'h1);
        press(gpm_pkg::IN_ACK);
        chk("shut_lamp", 32'h0, slamp);
        $display("Test shutdown done");
        // Auto run from the remote request, then a warning cleared by a remote reset cycle.
        pin(gpm_pkg::IN_OFF, 1'h0);
        pin(gpm_pkg::IN_AUTO, 1'h1);
        pin(gpm_pkg::IN_RSTART, 1'h1);
        chk("engine_run", 32'h1, eng);
        warn_c <= 1'h1;
        pin(gpm_pkg::IN_RSTART, 1'h0);
        chk("engine_run", 32'h0, eng);
        warn_c <= 1'h0;
        bus(1'h0, gpm_pkg::REG_STAT, 32'h0, d);
        chk("warn", 32'h1, d[gpm_pkg::ST_WARN]);
        press(gpm_pkg::IN_RRESET);
        bus(1'h0, gpm_pkg::REG_STAT, 32'h0, d);
        chk("warn", 32'h0, d[gpm_pkg::ST_WARN]);
        pin(gpm_pkg::IN_AUTO, 1'h0);
        pin(gpm_pkg::IN_OFF, 1'h1);
        $display("Test auto done");
        repeat (230) @(posedge clk);
        chk("disp_power", 32'h0, disp);
        chk("ctrl_active", 32'h1, act);
        bus(1'h1, gpm_pkg::REG_CTRL, 32'h1, d);
        repeat (230) @(posedge clk);
        chk("ctrl_active", 32'h0, act);
        press(gpm_pkg::IN_ACK);
        chk("ctrl_active", 32'h1, act);
        net_opt <= 1'h1;
        repeat (6) @(posedge clk);
        chk("cfg_err", 32'h1, cerr);
        $display("Test sleep done");
        summarize();
    end
endmodule
